//--- src/ces_pkg.sv
package ces_pkg;

	// ----------------------------------------
	// Widths and source counts
	// ----------------------------------------
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int N_EXT = 6;
	localparam int N_INT = 41;
	localparam int INT_GROUP_SHIFT = 3;
	localparam int N_INT_GROUPS = 6;

	// ----------------------------------------
	// Vector numbers (vector address = number times four)
	// ----------------------------------------
	localparam logic [7:0] VEC_RESET = 8'h00;
	localparam logic [7:0] VEC_NMI = 8'h07;
	localparam logic [7:0] VEC_TRAP_BASE = 8'h08;
	localparam logic [7:0] VEC_IRQ_BASE = 8'h0C;
	localparam logic [7:0] VEC_INT_BASE = 8'h14;
	localparam logic [7:0] VEC_INT_LAST = 8'h3C;
	localparam logic [23:0] VEC_HALF_STEP = 24'h000002;
	localparam logic [23:0] FRAME_BYTES = 24'h000004;

	// ----------------------------------------
	// Condition code bits
	// ----------------------------------------
	localparam int CCR_MASK_BIT = 7;
	localparam int CCR_UMASK_BIT = 6;
	localparam logic [7:0] CCR_RESET = 8'h80;

	// ----------------------------------------
	// Register map (byte addresses) and reset values
	// ----------------------------------------
	localparam logic [3:0] REG_SYSCTL = 4'h0;
	localparam logic [3:0] REG_PRIO_A = 4'h4;
	localparam logic [3:0] REG_PRIO_B = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hC;
	localparam logic [7:0] SYSCTL_RESET = 8'h0B;
	localparam logic [7:0] SYSCTL_WMASK = 8'hFD;
	localparam logic [7:0] SYSCTL_RO_ONES = 8'h02;
	localparam int SYSCTL_UE_BIT = 3;
	localparam logic [7:0] PRIO_RESET = 8'h00;

	// Least low time of the reset pin during operation (far side keeps it)
	localparam int RESET_MIN_CYCLES = 20;

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [6:0] {
		ST_RESET = 7'h01,
		ST_RUN = 7'h02,
		ST_PUSH_LO = 7'h04,
		ST_PUSH_HI = 7'h08,
		ST_VEC_HI = 7'h10,
		ST_VEC_LO = 7'h20,
		ST_LOAD = 7'h40
	} ces_state_type;

endpackage

//--- src/ces_arb_if.sv
`timescale 1ns/1ps
interface ces_arb_if;
	import ces_pkg::*;
	logic nmi;
	logic [N_EXT-1:0] ext_irq;
	logic [N_INT-1:0] int_irq;
	logic [7:0] prio_a;
	logic [7:0] prio_b;
	logic mask_i;
	logic mask_ui;
	logic ue;
	logic block_all;
	logic grant_valid;
	logic [7:0] grant_vec;

	modport arb (
		input nmi, ext_irq, int_irq, prio_a, prio_b, mask_i, mask_ui, ue, block_all,
		output grant_valid, grant_vec
	);
	modport seq (
		output nmi, ext_irq, int_irq, prio_a, prio_b, mask_i, mask_ui, ue, block_all,
		input grant_valid, grant_vec
	);
endinterface

//--- src/ces_arbiter.sv
`timescale 1ns/1ps
module ces_arbiter (
	ces_arb_if.arb bus
);
	import ces_pkg::*;

	logic found_hi;
	logic found_lo;
	logic [7:0] vec_hi;
	logic [7:0] vec_lo;
	logic allow_hi;
	logic allow_lo;

	// ----------------------------------------
	// Two-level search, lowest vector wins within a level
	// ----------------------------------------
	always_comb begin
		found_hi = 1'b0;
		found_lo = 1'b0;
		vec_hi = 8'h00;
		vec_lo = 8'h00;
		for (int i = N_INT - 1; i >= 0; i--) begin
			if (bus.int_irq[i]) begin
				if (bus.prio_b[i >> INT_GROUP_SHIFT]) begin
					found_hi = 1'b1;
					vec_hi = VEC_INT_BASE + 8'(i);
				end else begin
					found_lo = 1'b1;
					vec_lo = VEC_INT_BASE + 8'(i);
				end
			end
		end
		for (int i = N_EXT - 1; i >= 0; i--) begin
			if (bus.ext_irq[i]) begin
				if (bus.prio_a[i]) begin
					found_hi = 1'b1;
					vec_hi = VEC_IRQ_BASE + 8'(i);
				end else begin
					found_lo = 1'b1;
					vec_lo = VEC_IRQ_BASE + 8'(i);
				end
			end
		end
	end

	// Mask bit blocks all maskable; with UE clear, UI also drops level 0
	assign allow_hi = !bus.mask_i;
	assign allow_lo = !bus.mask_i && (bus.ue || !bus.mask_ui);

	always_comb begin
		bus.grant_valid = 1'b0;
		bus.grant_vec = 8'h00;
		if (bus.block_all) begin
			bus.grant_valid = 1'b0;
		end else if (bus.nmi) begin
			bus.grant_valid = 1'b1;
			bus.grant_vec = VEC_NMI;
		end else if (found_hi && allow_hi) begin
			bus.grant_valid = 1'b1;
			bus.grant_vec = vec_hi;
		end else if (found_lo && allow_lo) begin
			bus.grant_valid = 1'b1;
			bus.grant_vec = vec_lo;
		end
	end

endmodule

//--- src/ces_sequencer.sv
`timescale 1ns/1ps
// Functional notes
// - Reset outranks interrupts, interrupts outrank traps; one accepted at a time.
// - Trap requests are accepted whenever the core runs, with no mask.
// - Reset handling starts right after the reset pin rises.
// - Interrupts are taken only at instruction or exception completion.
// - Interrupt or trap entry first pushes program counter and condition codes.
// - After stacking the interrupt mask bit is set to one.
// - The source's vector is read and execution starts at its contents.
// - Reset entry skips stacking; it sets the mask and fetches the vector.
// - Reset reads its start address from the first four bytes.
// - Each source has its own vector at number times four.
// - The four trap sources use vectors eight to eleven.
// - While the reset pin is low everything but the register slave halts in reset.
// - Leaving reset initialises state and registers and sets the mask bit.
// - A watchdog overflow also resets the block.
// - Right after reset every interrupt, nonmaskable too, is blocked.
// - The first instruction after reset always runs before any interrupt.
// - The nonmaskable interrupt ranks highest and ignores the mask bits.
// - Other interrupts take one of two priority levels and are arbitrated.
// - Trap sets the mask bit, and also the user bit when enable is clear.
// - A trap picks one of four vectors by its encoded number.
// - Word accesses, stack pushes included, force address bit zero low.
// - User-bit enable clear makes the user bit a mask; set after reset.
module ces_sequencer (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic reset_pin_n_i,
	input wire logic wdt_overflow_i,
	input wire logic nmi_req_i,
	input wire logic [ces_pkg::N_EXT-1:0] ext_irq_lines_i,
	input wire logic [ces_pkg::N_INT-1:0] int_irq_i,
	input wire logic insn_done_i,
	input wire logic trap_req_i,
	input wire logic [1:0] trap_num_i,
	input wire logic [ces_pkg::ADDR_W-1:0] program_counter_i,
	input wire logic [7:0] cond_code_reg_i,
	input wire logic [ces_pkg::ADDR_W-1:0] stack_pointer_i,
	output logic core_hold_o,
	output logic load_pc_o,
	output logic load_sp_o,
	output logic trap_taken_o,
	output logic [ces_pkg::ADDR_W-1:0] new_pc_o,
	output logic [7:0] new_ccr_o,
	output logic [ces_pkg::ADDR_W-1:0] new_sp_o,
	output logic [7:0] exc_vector_o,
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [ces_pkg::ADDR_W-1:0] mem_addr_o,
	output logic [ces_pkg::DATA_W-1:0] mem_wdata_o,
	input wire logic [ces_pkg::DATA_W-1:0] mem_rdata_i,
	input wire logic mem_ack_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o
);
	import ces_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_W-1:0] a);
		return {a[ADDR_W-1:1], 1'b0};
	endfunction

	function automatic logic [ADDR_W-1:0] vec_addr(input logic [7:0] v);
		return {14'h0000, v, 2'h0};
	endfunction

	function automatic logic [7:0] entry_ccr(input logic [7:0] c, input logic also_ui);
		logic [7:0] r;
		r = c;
		r[CCR_MASK_BIT] = 1'b1;
		if (also_ui) begin
			r[CCR_UMASK_BIT] = 1'b1;
		end
		return r;
	endfunction

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic pin_meta_reg;
	logic pin_sync_reg;
	logic sys_rst;
	ces_state_type state_reg;
	ces_state_type state_next;
	logic take_irq;
	logic take_trap;
	logic chain_irq;
	logic xfer_done;
	logic first_block_reg;
	logic is_trap_reg;
	logic is_reset_reg;
	logic [7:0] vec_reg;
	logic [ADDR_W-1:0] work_pc_reg;
	logic [7:0] work_ccr_reg;
	logic [ADDR_W-1:0] work_sp_reg;
	logic [7:0] vec_hi_reg;
	logic [7:0] sysctl_reg;
	logic [7:0] prio_a_reg;
	logic [7:0] prio_b_reg;
	logic wait_reg;
	logic [7:0] mask_src;
	logic [31:0] rd_value;

	ces_arb_if arb_bus ();

	ces_arbiter u_arbiter (
		.bus(arb_bus.arb)
	);

	// ----------------------------------------
	// Reset pin synchroniser and system reset
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pin_meta_reg <= 1'b0;
			pin_sync_reg <= 1'b0;
		end else begin
			pin_meta_reg <= reset_pin_n_i;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// Watchdog overflow shares the pin's reset path
	assign sys_rst = !rst_n_i || !pin_sync_reg || wdt_overflow_i;

	// ----------------------------------------
	// Arbiter hookup
	// ----------------------------------------
	// Mask comes from the freshly built COND_CODE_REG when chaining out of LOAD,
	// since the core has not yet loaded it
	assign mask_src = (state_reg == ST_LOAD) ? new_ccr_o : cond_code_reg_i;
	assign arb_bus.nmi = nmi_req_i;
	assign arb_bus.ext_irq = ext_irq_lines_i;
	assign arb_bus.int_irq = int_irq_i;
	assign arb_bus.prio_a = prio_a_reg;
	assign arb_bus.prio_b = prio_b_reg;
	assign arb_bus.mask_i = mask_src[CCR_MASK_BIT];
	assign arb_bus.mask_ui = mask_src[CCR_UMASK_BIT];
	assign arb_bus.ue = sysctl_reg[SYSCTL_UE_BIT];
	assign arb_bus.block_all = first_block_reg;

	// ----------------------------------------
	// Acceptance
	// ----------------------------------------
	assign take_irq = (state_reg == ST_RUN) && insn_done_i && arb_bus.grant_valid;
	assign take_trap = (state_reg == ST_RUN) && trap_req_i && !take_irq;
	assign chain_irq = (state_reg == ST_LOAD) && arb_bus.grant_valid;
	assign xfer_done = mem_req_o && mem_ack_i;

	// ----------------------------------------
	// State machine
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_RESET: begin
				state_next = ST_VEC_HI;
			end
			ST_RUN: begin
				if (take_irq || take_trap) begin
					state_next = ST_PUSH_LO;
				end
			end
			ST_PUSH_LO: begin
				if (xfer_done) begin
					state_next = ST_PUSH_HI;
				end
			end
			ST_PUSH_HI: begin
				if (xfer_done) begin
					state_next = ST_VEC_HI;
				end
			end
			ST_VEC_HI: begin
				if (xfer_done) begin
					state_next = ST_VEC_LO;
				end
			end
			ST_VEC_LO: begin
				if (xfer_done) begin
					state_next = ST_LOAD;
				end
			end
			ST_LOAD: begin
				state_next = chain_irq ? ST_PUSH_LO : ST_RUN;
			end
			default: begin
				state_next = ST_RESET;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst) begin
			state_reg <= ST_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// Exception context
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst) begin
			vec_reg <= VEC_RESET;
			is_trap_reg <= 1'b0;
			is_reset_reg <= 1'b1;
			work_pc_reg <= '0;
			work_ccr_reg <= CCR_RESET;
			work_sp_reg <= '0;
		end else if (take_irq || chain_irq) begin
			vec_reg <= arb_bus.grant_vec;
			is_trap_reg <= 1'b0;
			is_reset_reg <= 1'b0;
			work_pc_reg <= chain_irq ? new_pc_o : program_counter_i;
			work_ccr_reg <= chain_irq ? new_ccr_o : cond_code_reg_i;
			work_sp_reg <= chain_irq ? new_sp_o : stack_pointer_i;
		end else if (take_trap) begin
			vec_reg <= VEC_TRAP_BASE + {6'h00, trap_num_i};
			is_trap_reg <= 1'b1;
			is_reset_reg <= 1'b0;
			work_pc_reg <= program_counter_i;
			work_ccr_reg <= cond_code_reg_i;
			work_sp_reg <= stack_pointer_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst) begin
			first_block_reg <= 1'b1;
		end else if (state_reg == ST_RUN && insn_done_i) begin
			first_block_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Memory master: stack pushes and vector reads
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst) begin
			mem_req_o <= 1'b0;
			mem_we_o <= 1'b0;
			mem_addr_o <= '0;
			mem_wdata_o <= '0;
		end else if (xfer_done) begin
			mem_req_o <= 1'b0;
			mem_we_o <= 1'b0;
		end else if (!mem_req_o) begin
			case (state_reg)
				ST_PUSH_LO: begin
					mem_req_o <= 1'b1;
					mem_we_o <= 1'b1;
					mem_addr_o <= word_addr(work_sp_reg - VEC_HALF_STEP);
					mem_wdata_o <= work_pc_reg[15:0];
				end
				ST_PUSH_HI: begin
					mem_req_o <= 1'b1;
					mem_we_o <= 1'b1;
					mem_addr_o <= word_addr(work_sp_reg - FRAME_BYTES);
					mem_wdata_o <= {work_ccr_reg, work_pc_reg[23:16]};
				end
				ST_VEC_HI: begin
					mem_req_o <= 1'b1;
					mem_we_o <= 1'b0;
					mem_addr_o <= vec_addr(vec_reg);
				end
				ST_VEC_LO: begin
					mem_req_o <= 1'b1;
					mem_we_o <= 1'b0;
					mem_addr_o <= vec_addr(vec_reg) + VEC_HALF_STEP;
				end
				default: begin
					mem_req_o <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Results handed to the core
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst) begin
			vec_hi_reg <= 8'h00;
			new_pc_o <= '0;
			new_ccr_o <= CCR_RESET;
			new_sp_o <= '0;
		end else begin
			if (state_reg == ST_PUSH_HI && xfer_done) begin
				// Mask set only once the old COND_CODE_REG is safely on the stack
				new_ccr_o <= entry_ccr(work_ccr_reg, is_trap_reg && !sysctl_reg[SYSCTL_UE_BIT]);
				new_sp_o <= work_sp_reg - FRAME_BYTES;
			end
			if (state_reg == ST_RESET) begin
				new_ccr_o <= CCR_RESET;
			end
			if (state_reg == ST_VEC_HI && xfer_done) begin
				vec_hi_reg <= mem_rdata_i[7:0];
			end
			if (state_reg == ST_VEC_LO && xfer_done) begin
				new_pc_o <= {vec_hi_reg, mem_rdata_i};
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst) begin
			core_hold_o <= 1'b1;
			load_pc_o <= 1'b0;
			load_sp_o <= 1'b0;
			trap_taken_o <= 1'b0;
			exc_vector_o <= VEC_RESET;
		end else begin
			core_hold_o <= (state_next != ST_RUN);
			load_pc_o <= (state_next == ST_LOAD);
			load_sp_o <= (state_next == ST_LOAD) && !is_reset_reg;
			trap_taken_o <= take_trap;
			if (state_next == ST_LOAD) begin
				exc_vector_o <= vec_reg;
			end
		end
	end

	// ----------------------------------------
	// Avalon-MM register slave, one wait state
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wait_reg <= 1'b1;
		end else if ((avs_read_i || avs_write_i) && wait_reg) begin
			wait_reg <= 1'b0;
		end else begin
			wait_reg <= 1'b1;
		end
	end

	assign avs_waitrequest_o = wait_reg;

	always_comb begin
		rd_value = 32'h00000000;
		case (avs_address_i)
			REG_SYSCTL: rd_value = {24'h000000, sysctl_reg | SYSCTL_RO_ONES};
			REG_PRIO_A: rd_value = {24'h000000, prio_a_reg};
			REG_PRIO_B: rd_value = {24'h000000, prio_b_reg};
			REG_STATUS: rd_value = {8'h00, first_block_reg, 1'b0, core_hold_o, 6'h00, state_reg, exc_vector_o};
			default: rd_value = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			avs_readdata_o <= 32'h00000000;
		end else if (avs_read_i && wait_reg) begin
			avs_readdata_o <= rd_value;
		end
	end

	// Control registers reinitialise on any reset cause
	always_ff @(posedge clk_i) begin
		if (sys_rst) begin
			sysctl_reg <= SYSCTL_RESET;
			prio_a_reg <= PRIO_RESET;
			prio_b_reg <= PRIO_RESET;
		end else if (avs_write_i && !wait_reg && avs_byteenable_i[0]) begin
			case (avs_address_i)
				REG_SYSCTL: sysctl_reg <= avs_writedata_i[7:0] & SYSCTL_WMASK;
				REG_PRIO_A: prio_a_reg <= avs_writedata_i[7:0];
				REG_PRIO_B: prio_b_reg <= avs_writedata_i[7:0];
				default: sysctl_reg <= sysctl_reg;
			endcase
		end
	end

endmodule

//--- test/ces_seq_props.sv
`timescale 1ns/1ps
module ces_seq_props (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic reset_pin_n_i,
	input wire logic wdt_overflow_i,
	input wire logic trap_req_i,
	input wire logic [23:0] stack_pointer_i,
	input wire logic core_hold_o,
	input wire logic load_pc_o,
	input wire logic load_sp_o,
	input wire logic trap_taken_o,
	input wire logic [7:0] new_ccr_o,
	input wire logic [23:0] new_sp_o,
	input wire logic [7:0] exc_vector_o,
	input wire logic mem_req_o,
	input wire logic mem_we_o,
	input wire logic [23:0] mem_addr_o,
	input wire logic mem_ack_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o
);
	// ----------------------------------------
	// Sequencer checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence second_push;
		mem_req_o && mem_we_o && mem_ack_i && mem_addr_o == stack_pointer_i - 24'h000004;
	endsequence
	sequence vector_read;
		mem_req_o && !mem_we_o && mem_addr_o < 24'h000100;
	endsequence
	pin_halt_a: assert property (!reset_pin_n_i [*5] |-> core_hold_o && !mem_req_o)
		else $error("core not halted while reset pin low");
	pin_release_a: assert property ($rose(reset_pin_n_i) |-> ##[2:12] (mem_req_o && mem_addr_o == 24'h000000))
		else $error("reset vector not fetched after pin release");
	wdt_reset_a: assert property (wdt_overflow_i |-> ##[1:3] (core_hold_o && new_ccr_o == 8'h80))
		else $error("watchdog overflow did not reset");
	reset_load_a: assert property (load_pc_o && !load_sp_o |-> exc_vector_o == 8'h00 && new_ccr_o == 8'h80)
		else $error("reset entry with wrong vector or flags");
	mask_set_a: assert property (load_pc_o |-> new_ccr_o[7])
		else $error("mask bit clear at entry");
	stack_frame_a: assert property (load_sp_o |-> load_pc_o && new_sp_o == stack_pointer_i - 24'h000004)
		else $error("stack pointer not lowered by frame");
	vector_range_a: assert property (load_sp_o |-> exc_vector_o inside {8'h07, [8'h08:8'h11], [8'h14:8'h3C]})
		else $error("entry vector outside table");
	word_align_a: assert property (mem_req_o |-> !mem_addr_o[0])
		else $error("odd word address");
	push_then_vec_a: assert property (second_push |-> ##[1:40] vector_read)
		else $error("no vector read after stacking");
	trap_pulse_a: assert property (trap_taken_o |-> $past(trap_req_i) && !$past(trap_taken_o))
		else $error("trap acceptance without request");
	avs_wait_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("register access not answered after one wait state");
	mem_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
		else $error("memory request changed before acknowledge");
endmodule
bind ces_sequencer ces_seq_props ces_seq_props_i (.*);

//--- test/ces_mem_model.sv
`timescale 1ns/1ps
module ces_mem_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic slow_i,
	input wire logic mem_req_i,
	input wire logic mem_we_i,
	input wire logic [23:0] mem_addr_i,
	input wire logic [15:0] mem_wdata_i,
	output logic [15:0] mem_rdata_o,
	output logic mem_ack_o,
	output logic [15:0] w_lo_o,
	output logic [15:0] w_hi_o
);
	logic [1:0] wait_reg;
	// ----------------------------------------
	// Word memory: table data from address, stack writes kept
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			mem_ack_o <= 1'b0;
			wait_reg <= 2'h0;
			mem_rdata_o <= 16'h0000;
			w_lo_o <= 16'h0000;
			w_hi_o <= 16'h0000;
		end else if (mem_ack_o || !mem_req_i) begin
			// Released data toggles so a late sample is caught
			mem_ack_o <= 1'b0;
			mem_rdata_o <= ~mem_rdata_o;
		end else if (slow_i && wait_reg != 2'h3) begin
			wait_reg <= wait_reg + 2'h1;
			mem_rdata_o <= ~mem_rdata_o;
		end else begin
			wait_reg <= 2'h0;
			mem_ack_o <= 1'b1;
			mem_rdata_o <= mem_addr_i[15:0] ^ 16'hA5C3;
			if (mem_we_i && mem_addr_i[1])
				w_lo_o <= mem_wdata_i;
			if (mem_we_i && !mem_addr_i[1])
				w_hi_o <= mem_wdata_i;
		end
	end
endmodule

//--- test/testbench.sv
`timescale 1ns/1ps
module testbench;
	import ces_pkg::*;
	logic clk_i = 1'b0, rst_n_i = 1'b0, reset_pin_n_i = 1'b1, wdt_overflow_i = 1'b0, slow = 1'b0;
	logic nmi_req_i = 1'b0, insn_done_i = 1'b0, trap_req_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
	logic mem_ack_i, core_hold_o, load_pc_o, load_sp_o, trap_taken_o, mem_req_o, mem_we_o, avs_waitrequest_o;
	logic [N_EXT-1:0] ext_irq_lines_i = '0;
	logic [N_INT-1:0] int_irq_i = '0;
	logic [1:0] trap_num_i = 2'h0;
	logic [ADDR_W-1:0] program_counter_i = 24'h123456, stack_pointer_i = 24'h00FF00, new_pc_o, new_sp_o, mem_addr_o;
	logic [7:0] cond_code_reg_i = 8'h80, new_ccr_o, exc_vector_o;
	logic [DATA_W-1:0] mem_wdata_o, mem_rdata_i, w_lo, w_hi;
	logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'hF;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
	int mismatches = 0, total_checks = 0, loads = 0;

	ces_sequencer ces_sequencer_i (.*);
	ces_mem_model ces_mem_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow), .mem_req_i(mem_req_o),
		.mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i),
		.mem_ack_o(mem_ack_i), .w_lo_o(w_lo), .w_hi_o(w_hi));

	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (load_pc_o === 1'b1)
			loads <= loads + 1;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic final_report();
		if (mismatches == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic fail();
		mismatches++;
		final_report();
	endtask
	task automatic check(string n, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %0h seen %0h", n, e, g);
		end
	endtask
	function automatic logic [15:0] rdw(logic [23:0] a);
		return a[15:0] ^ 16'hA5C3;
	endfunction
	task automatic av(logic we, logic [3:0] a, logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk_i);
		avs_address_i <= a;
		avs_writedata_i <= wd;
		avs_read_i <= !we;
		avs_write_i <= we;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 20);
		if (avs_waitrequest_o !== 1'b0)
			fail();
		rd = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask
	task automatic pulse();
		@(posedge clk_i);
		insn_done_i <= 1'b1;
		@(posedge clk_i);
		insn_done_i <= 1'b0;
	endtask
	task automatic quiet(int n);
		int l;
		l = loads;
		repeat (n) @(posedge clk_i);
		check("no_entry", l, loads);
	endtask
	task automatic wait_push();
		int n;
		n = 0;
		while (!(mem_req_o === 1'b1 && mem_we_o === 1'b1) && n < 100) begin
			@(negedge clk_i);
			n++;
		end
		if (n >= 100)
			fail();
		@(posedge clk_i);
	endtask
	// Waits for the load pulse and judges PC, vector, flags, load_sp and pushes
	task automatic entry(logic [7:0] v, logic [7:0] c, logic sp);
		int n;
		logic [23:0] a;
		a = {14'h0, v, 2'b00};
		n = 0;
		while (load_pc_o !== 1'b1 && n < 400) begin
			@(negedge clk_i);
			n++;
		end
		if (n >= 400)
			fail();
		check("new_pc", {8'(rdw(a)), rdw(a + 24'h2)}, new_pc_o);
		check("vector", v, exc_vector_o);
		check("new_ccr", c, new_ccr_o);
		check("load_sp", sp, load_sp_o);
		if (sp) begin
			check("push_lo", program_counter_i[15:0], w_lo);
			check("push_hi", {cond_code_reg_i, program_counter_i[23:16]}, w_hi);
		end
		@(posedge clk_i);
	endtask
	task automatic trap(logic [1:0] t, logic [7:0] c, logic raise);
		int n;
		n = 0;
		if (raise) begin
			@(posedge clk_i);
			trap_req_i <= 1'b1;
			trap_num_i <= t;
		end
		while (trap_taken_o !== 1'b1 && n < 200) begin
			@(negedge clk_i);
			n++;
		end
		if (n >= 200)
			fail();
		@(posedge clk_i);
		trap_req_i <= 1'b0;
		entry(8'h08 + t, c, 1'b1);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic s_reset();
		entry(8'h00, 8'h80, 1'b0);
		av(1'b0, 4'h0, 32'h0);
		check("sysctl", 32'h0B, rd);
		av(1'b0, 4'hC, 32'h0);
		check("status", 32'h00800200, rd);
		av(1'b0, 4'h2, 32'h0);
		check("unmapped", 32'h0, rd);
	endtask
	task automatic s_block();
		@(posedge clk_i);
		nmi_req_i <= 1'b1;
		pulse();
		quiet(12);
		pulse();
		wait_push();
		nmi_req_i <= 1'b0;
		entry(8'h07, 8'h80, 1'b1);
	endtask
	task automatic s_irq();
		slow <= 1'b1;
		ext_irq_lines_i <= 6'h04;
		pulse();
		// Long enough to cover a whole slow-memory entry
		quiet(40);
		cond_code_reg_i <= 8'h00;
		pulse();
		wait_push();
		ext_irq_lines_i <= 6'h00;
		entry(8'h0E, 8'h80, 1'b1);
		for (int k = 0; k < 2; k++) begin
			int_irq_i <= N_INT'(1) << (k * 40);
			pulse();
			wait_push();
			int_irq_i <= '0;
			entry(8'h14 + 8'(k * 40), 8'h80, 1'b1);
		end
		av(1'b1, 4'h4, 32'h04);
		av(1'b0, 4'h4, 32'h0);
		check("prio_a", 32'h04, rd);
		// Low byte lane disabled: write must be ignored
		avs_byteenable_i <= 4'hE;
		av(1'b1, 4'h4, 32'h3F);
		avs_byteenable_i <= 4'hF;
		av(1'b0, 4'h4, 32'h0);
		check("prio_a_be", 32'h04, rd);
		ext_irq_lines_i <= 6'h06;
		pulse();
		wait_push();
		ext_irq_lines_i <= 6'h02;
		entry(8'h0E, 8'h80, 1'b1);
		pulse();
		wait_push();
		ext_irq_lines_i <= 6'h00;
		entry(8'h0D, 8'h80, 1'b1);
		slow <= 1'b0;
	endtask
	task automatic s_prio();
		@(posedge clk_i);
		nmi_req_i <= 1'b1;
		trap_req_i <= 1'b1;
		trap_num_i <= 2'h1;
		insn_done_i <= 1'b1;
		@(posedge clk_i);
		insn_done_i <= 1'b0;
		wait_push();
		nmi_req_i <= 1'b0;
		entry(8'h07, 8'h80, 1'b1);
		trap(2'h1, 8'h80, 1'b0);
	endtask
	task automatic s_trap();
		// Odd stack pointer: pushes must still land on even words
		stack_pointer_i <= 24'h00FF01;
		for (int t = 0; t < 4; t++)
			trap(2'(t), 8'h80, 1'b1);
		av(1'b1, 4'h0, 32'h0);
		av(1'b0, 4'h0, 32'h0);
		check("sysctl_ue0", 32'h02, rd);
		trap(2'h3, 8'hC0, 1'b1);
	endtask
	task automatic s_resets();
		@(posedge clk_i);
		wdt_overflow_i <= 1'b1;
		@(posedge clk_i);
		wdt_overflow_i <= 1'b0;
		entry(8'h00, 8'h80, 1'b0);
		av(1'b0, 4'h0, 32'h0);
		check("sysctl_init", 32'h0B, rd);
		av(1'b0, 4'h4, 32'h0);
		check("prio_init", 32'h0, rd);
		@(posedge clk_i);
		reset_pin_n_i <= 1'b0;
		// Low for the least time a running part must see
		repeat (RESET_MIN_CYCLES) @(negedge clk_i);
		check("hold", 1'b1, core_hold_o);
		check("mem_idle", 1'b0, mem_req_o);
		@(posedge clk_i);
		reset_pin_n_i <= 1'b1;
		entry(8'h00, 8'h80, 1'b0);
	endtask

	initial begin
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		s_reset();
		s_block();
		s_irq();
		s_prio();
		s_trap();
		s_resets();
		final_report();
	end
endmodule
